// File: dv/i2sap_far.sv
`timescale 1ns/1ps
`default_nettype none

module i2sap_far (
    // Frame control
    input  wire logic        run,
    input  wire logic [5:0]  slot_len,
    input  wire logic [31:0] word_lo,
    input  wire logic [31:0] word_hi,
    // Resolved link levels
    input  wire logic        sck_i,
    input  wire logic        ws_i,
    input  wire logic        sd_i,
    // Levels driven from this side
    output logic             sck_o,
    output logic             ws_o,
    output logic             sd_o,
    // Captured words by select level
    output logic [31:0]      cap_lo,
    output logic [31:0]      cap_hi,
    output logic [5:0]       bits
);
    logic [5:0]  gen_n = 6'h00;
    logic [5:0]  tx_n  = 6'h20;
    logic [5:0]  rx_n  = 6'h00;
    logic [31:0] sh    = 32'h0000_0000;
    logic        ws_r  = 1'b0;
    logic        start = 1'b0;
    logic [31:0] w;
    logic [31:0] sh_n;

    assign w    = ws_r ? word_hi : word_lo;
    assign sh_n = {sh[30:0], sd_i};

    // clock and select
    // The clock stands still low outside frames, so no stray edge reaches the port.
    initial begin
        sck_o = 1'b0;
        ws_o  = 1'b0;
        sd_o  = 1'b0;
        #13;
        forever begin
            #200;
            if (run && sck_o) begin
                sck_o = 1'b0;
                gen_n = gen_n + 6'h01;
                if (gen_n >= slot_len) begin
                    gen_n = 6'h00;
                    ws_o  = ~ws_o;
                end
            end else begin
                sck_o = run;
            end
        end
    end

    always @(posedge sck_i) begin
        ws_r <= ws_i;
        if (ws_i != ws_r) begin
            if (ws_r) cap_hi <= sh_n;
            else cap_lo <= sh_n;
            bits  <= rx_n + 6'h01;
            rx_n  <= 6'h00;
            sh    <= 32'h0000_0000;
            start <= 1'b1;
        end else begin
            rx_n <= rx_n + 6'h01;
            sh   <= sh_n;
        end
    end

    always @(negedge sck_i) begin
        if (start) begin
            sd_o  <= w[31];
            tx_n  <= 6'h01;
            start <= 1'b0;
        end else begin
            sd_o <= (tx_n < 6'h20) ? w[5'h1F - tx_n[4:0]] : 1'b0;
            tx_n <= (tx_n < 6'h20) ? tx_n + 6'h01 : tx_n;
        end
    end
endmodule

`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import i2sap_pkg::*;
    localparam logic [31:0] WL = 32'hA5C3_0F7E;
    localparam logic [31:0] WH = 32'h1234_56FF;
    logic              clock  = 1'b0;
    logic              arst_n = 1'b0;
    logic              en     = 1'b0;
    logic              slv    = 1'b1;
    logic              txs    = 1'b0;
    logic              pol    = 1'b1;
    logic              run    = 1'b0;
    logic [5:0]        slen   = 6'h20;
    logic [WORD_W-1:0] tl     = 24'hC0_FFEE;
    logic [WORD_W-1:0] tr     = 24'h81_2345;
    logic              sck, ws, sd, sck_d, sck_oe_n, ws_d, ws_oe_n, sd_d, sd_oe_n;
    logic              sck_p, ws_p, sd_p, take, take_l, rx_l, rx_v;
    logic [WORD_W-1:0] rx_d;
    logic [31:0]       c_lo, c_hi;
    logic [5:0]        bits;
    int                n_fail     = 0;
    int                n_compared = 0;

    assign sck = sck_oe_n ? sck_p : sck_d;
    assign ws  = ws_oe_n ? ws_p : ws_d;
    assign sd  = sd_oe_n ? sd_p : sd_d;

    i2sap_top dut (
        .clock(clock), .arst_n(arst_n), .block_enable(en), .slave_select(slv),
        .tx_select(txs), .lr_polarity_select(pol), .half_period(8'h03),
        .bit_clock_pin_zero_i(sck), .bit_clock_pin_zero_o(sck_d),
        .bit_clock_pin_zero_oe_n(sck_oe_n), .word_select_pin_zero_i(ws),
        .word_select_pin_zero_o(ws_d), .word_select_pin_zero_oe_n(ws_oe_n),
        .serial_data_i(sd), .serial_data_o(sd_d), .serial_data_oe_n(sd_oe_n),
        .tx_left_data(tl), .tx_right_data(tr), .tx_take(take), .tx_take_left(take_l),
        .rx_data(rx_d), .rx_left(rx_l), .rx_valid(rx_v)
    );

    i2sap_far far (
        .run(run), .slot_len(slen), .word_lo(WL), .word_hi(WH), .sck_i(sck), .ws_i(ws),
        .sd_i(sd), .sck_o(sck_p), .ws_o(ws_p), .sd_o(sd_p), .cap_lo(c_lo), .cap_hi(c_hi),
        .bits(bits)
    );

    initial begin
        forever #25 clock = ~clock;
    end

    task automatic summarize();
        if (n_fail == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // A lost pulse would otherwise hang the run, so every wait is bounded.
    task automatic wait_ev(input logic tx);
        for (int i = 0; i < 1500; i++) begin
            @(posedge clock);
            #1;
            if ((tx ? take : rx_v) === 1'b1) return;
        end
        chk("wait_bound", 32'h0000_0000, 32'h0000_0001);
        summarize();
    endtask

    task automatic setup(input logic s, t, p, r, input logic [5:0] l);
        @(posedge clock);
        en   <= 1'b0;
        slv  <= s;
        txs  <= t;
        pol  <= p;
        run  <= r;
        slen <= l;
        @(posedge clock);
        en <= 1'b1;
    endtask

    task automatic t_pins();
        chk("reset_outputs", 32'h0000_0000, 32'({take, rx_v, sd_d, sck_d, ws_d, rx_d}));
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            {en, slv, txs} <= 3'(i);
            @(negedge clock);
            chk("clock_oe_n", 32'(!(en && !slv)), 32'(sck_oe_n));
            chk("select_oe_n", 32'(!(en && !slv)), 32'(ws_oe_n));
            chk("data_oe_n", 32'(!(en && txs)), 32'(sd_oe_n));
        end
        @(posedge clock);
        {en, slv} <= 2'b00;
        repeat (20) begin
            @(negedge clock);
            chk("idle_clock", 32'h0000_0000, 32'(sck_d));
        end
    endtask

    task automatic t_rx(input logic s, p, input logic [5:0] l, input logic [23:0] e0, e1);
        logic last;
        setup(s, 1'b0, p, s, l);
        wait_ev(1'b0);
        wait_ev(1'b0);
        last = rx_l;
        repeat (4) begin
            wait_ev(1'b0);
            chk("rx_data", 32'(rx_l === p ? e0 : e1), 32'(rx_d));
            chk("rx_left", 32'(!last), 32'(rx_l));
            last = rx_l;
        end
    endtask

    task automatic t_tx(input logic s, p);
        logic last;
        setup(s, 1'b1, p, s, 6'h20);
        wait_ev(1'b1);
        last = take_l;
        repeat (5) begin
            wait_ev(1'b1);
            chk("take_left", 32'(!last), 32'(take_l));
            last = take_l;
        end
        chk("ws_low_word", {p ? tl : tr, 8'h00}, c_lo);
        chk("ws_high_word", {p ? tr : tl, 8'h00}, c_hi);
        chk("slot_bits", 32'(SLOT_BITS), 32'(bits));
    endtask

    initial begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_pins();
        t_rx(1'b1, 1'b1, 6'h20, WL[31:8], WH[31:8]);
        t_rx(1'b1, 1'b0, 6'h10, {WL[31:16], 8'h00}, {WH[31:16], 8'h00});
        t_rx(1'b0, 1'b1, 6'h20, WL[31:8], WH[31:8]);
        t_tx(1'b1, 1'b1);
        t_tx(1'b0, 1'b0);
        summarize();
    end
endmodule

`default_nettype wire

// File: include/i2sap_pkg.sv
package i2sap_pkg;

    // Word length of this port, in bits, for both directions.
    localparam int unsigned WORD_W    = 24;
    // Bit periods per channel slot when this port is master.
    localparam int unsigned SLOT_BITS = 32;
    // Width of the bit counters; the receive and transmit counters saturate at all ones.
    localparam int unsigned CNT_W     = 6;
    // Width of the master half-period divider.
    localparam int unsigned DIV_W     = 8;
    // Number of pins passed through the synchroniser: clock, select, data.
    localparam int unsigned PIN_N     = 3;

    localparam logic [CNT_W-1:0]  CNT_RST  = 6'h00;
    localparam logic [CNT_W-1:0]  CNT_MAX  = 6'h3F;
    localparam logic [CNT_W-1:0]  CNT_WORD = 6'h18;
    localparam logic [CNT_W-1:0]  CNT_SLOT = 6'h1F;
    localparam logic [DIV_W-1:0]  DIV_RST  = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RST = 24'h00_0000;

    // Pin bit positions in the synchroniser vector.
    localparam int unsigned PIN_SCK = 0;
    localparam int unsigned PIN_WS  = 1;
    localparam int unsigned PIN_SD  = 2;

endpackage

// File: rtl/i2sap_clkgen.sv
`timescale 1ns/1ps
`default_nettype none

module i2sap_clkgen
    import i2sap_pkg::*;
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             arst_n,
    // Control
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] half_period,
    // Generated link levels
    output logic                  sck_o,
    output logic                  ws_o
);

    typedef struct packed {
        logic [DIV_W-1:0] div_cnt;
        logic             sck;
        logic             ws;
        logic [CNT_W-1:0] bit_cnt;
    } i2sap_gen_s;

    i2sap_gen_s st_q;
    i2sap_gen_s st_d;

    always_comb begin
        st_d = st_q;
        if (!run) begin
            // Stopping returns to idle so that a restart begins a clean slot with select low.
            st_d.div_cnt = DIV_RST;
            st_d.sck     = 1'b0;
            st_d.ws      = 1'b0;
            st_d.bit_cnt = CNT_RST;
        end else if (st_q.div_cnt == half_period) begin
            st_d.div_cnt = DIV_RST;
            st_d.sck     = ~st_q.sck;
            if (st_q.sck) begin
                if (st_q.bit_cnt == CNT_SLOT) begin
                    st_d.bit_cnt = CNT_RST;
                    st_d.ws      = ~st_q.ws;
                end else begin
                    st_d.bit_cnt = st_q.bit_cnt + 6'h01;
                end
            end
        end else begin
            st_d.div_cnt = st_q.div_cnt + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sck_o = st_q.sck;
    assign ws_o  = st_q.ws;

endmodule

`default_nettype wire

// File: rtl/i2sap_sync.sv
`timescale 1ns/1ps
`default_nettype none

module i2sap_sync
    import i2sap_pkg::*;
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             arst_n,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [PIN_N-1:0] async_i,
    output logic      [PIN_N-1:0] sync_o
);

    typedef struct packed {
        logic [PIN_N-1:0] stage1;
        logic [PIN_N-1:0] stage2;
    } i2sap_sync_s;

    i2sap_sync_s st_q;
    i2sap_sync_s st_d;

    always_comb begin
        st_d        = st_q;
        st_d.stage1 = async_i;
        st_d.stage2 = st_q.stage1;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.stage2;

endmodule

`default_nettype wire

// File: rtl/i2sap_top.sv
`timescale 1ns/1ps
`default_nettype none

module i2sap_top
    import i2sap_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              arst_n,
    // Control levels
    input  wire logic              block_enable,
    input  wire logic              slave_select,
    input  wire logic              tx_select,
    input  wire logic              lr_polarity_select,
    input  wire logic [DIV_W-1:0]  half_period,
    // Bit clock pin
    input  wire logic              bit_clock_pin_zero_i,
    output logic                   bit_clock_pin_zero_o,
    output logic                   bit_clock_pin_zero_oe_n,
    // Word select pin
    input  wire logic              word_select_pin_zero_i,
    output logic                   word_select_pin_zero_o,
    output logic                   word_select_pin_zero_oe_n,
    // Serial data pin
    input  wire logic              serial_data_i,
    output logic                   serial_data_o,
    output logic                   serial_data_oe_n,
    // Transmit samples
    input  wire logic [WORD_W-1:0] tx_left_data,
    input  wire logic [WORD_W-1:0] tx_right_data,
    output logic                   tx_take,
    output logic                   tx_take_left,
    // Received samples
    output logic [WORD_W-1:0]      rx_data,
    output logic                   rx_left,
    output logic                   rx_valid
);

    typedef struct packed {
        logic              sck_prev;
        logic              ws_q;
        logic              start_pend;
        logic [WORD_W-1:0] rx_shift;
        logic [CNT_W-1:0]  rx_cnt;
        logic [WORD_W-1:0] rx_word;
        logic              rx_left;
        logic              rx_valid;
        logic [WORD_W-1:0] tx_shift;
        logic [CNT_W-1:0]  tx_cnt;
        logic              sd_out;
        logic              tx_take;
        logic              tx_take_left;
    } i2sap_core_s;

    i2sap_core_s st_q;
    i2sap_core_s st_d;

    logic [PIN_N-1:0] pins_sync;
    logic             gen_sck;
    logic             gen_ws;
    logic             master_run;
    logic             sck_lvl;
    logic             ws_lvl;
    logic             sd_lvl;
    logic             rise_p;
    logic             fall_p;
    logic             ws_chg;
    logic             new_left;
    logic [WORD_W-1:0] tx_word;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] cnt);
        sat_inc = (cnt == CNT_MAX) ? cnt : cnt + 6'h01;
    endfunction

    i2sap_sync u_sync (
        .clock   (clock),
        .arst_n  (arst_n),
        .async_i ({serial_data_i, word_select_pin_zero_i, bit_clock_pin_zero_i}),
        .sync_o  (pins_sync)
    );

    assign master_run = block_enable & ~slave_select;

    i2sap_clkgen u_clkgen (
        .clock       (clock),
        .arst_n      (arst_n),
        .run         (master_run),
        .half_period (half_period),
        .sck_o       (gen_sck),
        .ws_o        (gen_ws)
    );

    assign sck_lvl = slave_select ? pins_sync[PIN_SCK] : gen_sck;
    assign ws_lvl  = slave_select ? pins_sync[PIN_WS] : gen_ws;
    assign sd_lvl  = pins_sync[PIN_SD];

    // Pin edges are seen two clocks late, so the bit clock must span several system clocks.
    assign rise_p = block_enable & sck_lvl & ~st_q.sck_prev;
    assign fall_p = block_enable & ~sck_lvl & st_q.sck_prev;
    assign ws_chg = ws_lvl ^ st_q.ws_q;

    assign new_left = st_q.ws_q ^ lr_polarity_select;
    assign tx_word  = new_left ? tx_left_data : tx_right_data;

    always_comb begin
        st_d          = st_q;
        st_d.sck_prev = sck_lvl;
        st_d.rx_valid = 1'b0;
        st_d.tx_take  = 1'b0;
        if (rise_p) begin
            st_d.ws_q = ws_lvl;
            if (!tx_select) begin
                if (st_q.rx_cnt < CNT_WORD) begin
                    st_d.rx_shift[WORD_W-1-st_q.rx_cnt] = sd_lvl;
                end
                st_d.rx_cnt = sat_inc(st_q.rx_cnt);
            end
            if (ws_chg) begin
                st_d.start_pend = 1'b1;
                if (!tx_select) begin
                    st_d.rx_word  = st_d.rx_shift;
                    st_d.rx_left  = st_q.ws_q ^ lr_polarity_select;
                    st_d.rx_valid = 1'b1;
                    st_d.rx_shift = WORD_RST;
                    st_d.rx_cnt   = CNT_RST;
                end
            end
        end
        if (fall_p && tx_select) begin
            if (st_q.start_pend) begin
                st_d.sd_out       = tx_word[WORD_W-1];
                st_d.tx_shift     = {tx_word[WORD_W-2:0], 1'b0};
                st_d.tx_cnt       = 6'h01;
                st_d.start_pend   = 1'b0;
                st_d.tx_take      = 1'b1;
                st_d.tx_take_left = new_left;
            end else begin
                st_d.sd_out   = st_q.tx_shift[WORD_W-1];
                st_d.tx_shift = {st_q.tx_shift[WORD_W-2:0], 1'b0};
                st_d.tx_cnt   = sat_inc(st_q.tx_cnt);
            end
        end else if (fall_p) begin
            st_d.start_pend = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign bit_clock_pin_zero_o      = gen_sck;
    assign bit_clock_pin_zero_oe_n   = ~master_run;
    assign word_select_pin_zero_o    = gen_ws;
    assign word_select_pin_zero_oe_n = ~master_run;
    assign serial_data_o             = st_q.sd_out;
    assign serial_data_oe_n          = ~(block_enable & tx_select);

    assign tx_take      = st_q.tx_take;
    assign tx_take_left = st_q.tx_take_left;
    assign rx_data      = st_q.rx_word;
    assign rx_left      = st_q.rx_left;
    assign rx_valid     = st_q.rx_valid;

    ws_capture_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        rise_p |=> (st_q.ws_q == $past(ws_lvl)))
    else $error("Word select not captured on rising edge.");

    rx_store_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        (rise_p && ws_chg && !tx_select) |=> (rx_valid && st_q.rx_cnt == CNT_RST
        && st_q.rx_shift == WORD_RST))
    else $error("Receiver did not store and clear on select change.");

    rx_discard_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        (rise_p && !ws_chg && st_q.rx_cnt >= CNT_WORD) |=> $stable(st_q.rx_shift))
    else $error("Receiver kept a bit beyond its word length.");

    rx_sample_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        (rise_p && !ws_chg && !tx_select && st_q.rx_cnt == CNT_RST)
        |=> (st_q.rx_shift[WORD_W-1] == $past(sd_lvl)))
    else $error("Most significant bit not sampled on rising edge.");

    msb_first_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        (fall_p && tx_select && st_q.start_pend)
        |=> (serial_data_o == $past(tx_word[WORD_W-1])) && tx_take)
    else $error("Most significant bit not sent after select change.");

    zero_pad_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        (fall_p && tx_select && !st_q.start_pend && st_q.tx_cnt >= CNT_WORD)
        |=> (serial_data_o == 1'b0))
    else $error("Slot bits after the word are not zero.");

    tx_edge_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        !fall_p |=> $stable(serial_data_o))
    else $error("Transmit data changed away from a falling edge.");

    pin_dir_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        (slave_select |-> (bit_clock_pin_zero_oe_n && word_select_pin_zero_oe_n))
        and ((block_enable && !slave_select) |-> !bit_clock_pin_zero_oe_n))
    else $error("Clock or select pin direction wrong for mode.");

    polarity_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        (rise_p && ws_chg && !tx_select)
        |=> (rx_left == ($past(st_q.ws_q) ^ $past(lr_polarity_select))))
    else $error("Channel flag disagrees with polarity setting.");

    tx_shift_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        (fall_p && tx_select && !st_q.start_pend)
        |=> (serial_data_o == $past(st_q.tx_shift[WORD_W-1])))
    else $error("Transmit bit not taken from the top of the shifter.");

    rx_pulse_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        rx_valid |=> !rx_valid)
    else $error("Receive strobe lasted more than one cycle.");

    take_pulse_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        tx_take |=> !tx_take)
    else $error("Load strobe lasted more than one cycle.");

    rx_hold_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        !rx_valid |-> ($stable(rx_data) && $stable(rx_left)))
    else $error("Stored sample changed without a store.");

    take_left_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        tx_take |-> (tx_take_left == $past(new_left)))
    else $error("Loaded channel flag disagrees with select level.");

    gen_idle_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        !master_run |=> (!bit_clock_pin_zero_o && !word_select_pin_zero_o))
    else $error("Generated clock or select not idle while master is off.");

    ws_dir_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        (block_enable && !slave_select) |-> !word_select_pin_zero_oe_n)
    else $error("Select pin not driven in master mode.");

    data_dir_a:
    assert property (@(posedge clock) disable iff (!arst_n)
        serial_data_oe_n != (block_enable && tx_select))
    else $error("Data pin direction wrong for mode.");

endmodule

`default_nettype wire
